/* File: hw/usb_host_channel_result_config.sv */
// host channel result code and basic configuration with AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
module usb_host_channel_result_config #(
  parameter int LEN_W = usb_chan_pkg::LEN_W,
  parameter int TOT_W = usb_chan_pkg::TOT_W
) (
  input wire logic clk, // system clock, 250 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [usb_chan_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic [2:0] awprot, // unused protection
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [usb_chan_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic [2:0] arprot, // unused protection
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  input wire logic ctl_done, // control-channel transfer ended
  input wire usb_chan_pkg::pkt_status_type ctl_status, // end checks
  input wire logic [LEN_W-1:0] ctl_rx_len, // last packet length
  input wire logic [LEN_W-1:0] ctl_max_pkt, // max packet size
  input wire logic [TOT_W-1:0] ctl_rx_total, // bytes received
  input wire logic [TOT_W-1:0] ctl_budget, // transfer byte budget
  input wire logic txn_busy, // general transaction in flight
  input wire logic txn_end, // general transaction ended
  input wire logic xfer_complete, // whole budget moved
  input wire logic ack_pulse, // ACK on general channel
  input wire logic bot_active, // bulk-only assist running
  input wire logic ack_is_data, // ACK from data transport
  input wire logic toggle_upd, // engine toggle update strobe
  input wire logic toggle_val, // engine toggle value
  output usb_chan_pkg::chan_cfg_type chan_cfg, // settings to engine
  output logic [2:0] ctl_result, // current result code
  output logic ack_count_reached_flag, // sticky ACK target flag
  output logic stop_done_flag // sticky stop-done flag
);
  typedef struct packed {
    usb_chan_pkg::wr_state_type wr_state;
    logic aw_got;
    logic w_got;
    logic [9:0] w_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
    logic [2:0] result;
    usb_chan_pkg::chan_cfg_type cfg;
    logic ack_flag;
    logic stop_flag;
    logic stop_pending;
  } state_type;

  state_type state_q;
  state_type state_d;
  logic [2:0] class_code;
  logic ack_reached;
  logic launch_rise;
  logic aw_take;
  logic w_take;
  logic commit;
  logic [9:0] c_idx;
  logic [7:0] c_byte;
  logic c_lane0;
  logic [9:0] r_idx;
  logic [1:0] new_speed;

  result_classifier #(
    .LEN_W(LEN_W),
    .TOT_W(TOT_W)
  ) u_classify (
    .status(ctl_status),
    .rx_len(ctl_rx_len),
    .max_pkt(ctl_max_pkt),
    .rx_total(ctl_rx_total),
    .budget(ctl_budget),
    .code(class_code)
  );

  ack_counter #(
    .CNT_W(5)
  ) u_acks (
    .clk(clk),
    .reset_n(reset_n),
    .restart(launch_rise),
    .ack_pulse(ack_pulse),
    .bot_active(bot_active),
    .ack_is_data(ack_is_data),
    .target_code(state_q.cfg.ack_code),
    .reached(ack_reached)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes
  assign awready = (state_q.wr_state == usb_chan_pkg::WR_COLLECT) &&
                   !state_q.aw_got;
  assign wready = (state_q.wr_state == usb_chan_pkg::WR_COLLECT) &&
                  !state_q.w_got;
  assign arready = !state_q.rvalid;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign commit = (state_q.aw_got || aw_take) && (state_q.w_got || w_take);
  assign c_idx = state_q.aw_got ? state_q.w_idx :
                 awaddr[usb_chan_pkg::ADDR_W-1:usb_chan_pkg::IDX_LSB];
  assign c_byte = state_q.w_got ? state_q.w_byte : wdata[7:0];
  assign c_lane0 = state_q.w_got ? state_q.w_lane0 : wstrb[0];
  assign r_idx = araddr[usb_chan_pkg::ADDR_W-1:usb_chan_pkg::IDX_LSB];
  assign new_speed =
    c_byte[usb_chan_pkg::CFG_SPEED_MSB:usb_chan_pkg::CFG_SPEED_LSB];

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_d = state_q;
    launch_rise = 1'b0;
    // write channel: address and data may arrive in either order
    case (state_q.wr_state)
      usb_chan_pkg::WR_COLLECT: begin
        if (aw_take) begin
          state_d.aw_got = 1'b1;
          state_d.w_idx =
            awaddr[usb_chan_pkg::ADDR_W-1:usb_chan_pkg::IDX_LSB];
        end
        if (w_take) begin
          state_d.w_got = 1'b1;
          state_d.w_byte = wdata[7:0];
          state_d.w_lane0 = wstrb[0];
        end
        if (commit) begin
          state_d.wr_state = usb_chan_pkg::WR_RESP;
          state_d.aw_got = 1'b0;
          state_d.w_got = 1'b0;
          state_d.bresp = (c_idx == usb_chan_pkg::IDX_RESULT ||
                           c_idx == usb_chan_pkg::IDX_CONFIG ||
                           c_idx == usb_chan_pkg::IDX_EVENT) ?
                          usb_chan_pkg::AXI_OKAY : usb_chan_pkg::AXI_SLVERR;
        end
      end
      usb_chan_pkg::WR_RESP: begin
        if (bready) begin
          state_d.wr_state = usb_chan_pkg::WR_COLLECT;
        end
      end
      default: begin
        state_d.wr_state = usb_chan_pkg::WR_COLLECT;
      end
    endcase

    // engine side first so a software write in the same cycle wins; its toggle bit only while txn_busy is low
    if (toggle_upd) begin
      state_d.cfg.toggle = toggle_val;
    end
    if (xfer_complete) begin
      state_d.cfg.launch = 1'b0;
    end

    // writes to the result index are accepted and dropped
    if (commit && c_lane0) begin
      if (c_idx == usb_chan_pkg::IDX_CONFIG) begin
        state_d.cfg.ack_code =
          c_byte[usb_chan_pkg::CFG_ACK_MSB:usb_chan_pkg::CFG_ACK_LSB];
        // prohibited speed codes keep the previous setting
        if (new_speed < usb_chan_pkg::SPEED_FIRST_BAD) begin
          state_d.cfg.speed = new_speed;
        end
        // a running transaction owns the live toggle value
        if (!txn_busy) begin
          state_d.cfg.toggle = c_byte[usb_chan_pkg::CFG_TOGGLE_BIT];
        end
        if (c_byte[usb_chan_pkg::CFG_LAUNCH_BIT] && !state_q.cfg.launch) begin
          state_d.cfg.launch = 1'b1;
          state_d.stop_pending = 1'b0;
          launch_rise = 1'b1;
        end else if (!c_byte[usb_chan_pkg::CFG_LAUNCH_BIT] &&
                     state_q.cfg.launch) begin
          state_d.cfg.launch = 1'b0;
          state_d.stop_pending = txn_busy;
        end
      end
      if (c_idx == usb_chan_pkg::IDX_EVENT) begin
        if (c_byte[usb_chan_pkg::EVT_ACK_BIT]) begin
          state_d.ack_flag = 1'b0;
        end
        if (c_byte[usb_chan_pkg::EVT_STOP_BIT]) begin
          state_d.stop_flag = 1'b0;
        end
      end
    end

    // hardware sets after the clear so a same-cycle event is kept
    if (ack_reached) begin
      state_d.ack_flag = 1'b1;
    end
    if (txn_end && state_q.stop_pending) begin
      state_d.stop_flag = 1'b1;
      state_d.stop_pending = 1'b0;
    end

    if (ctl_done) begin
      state_d.result = class_code;
    end

    // read channel
    if (state_q.rvalid && rready) begin
      state_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = usb_chan_pkg::AXI_OKAY;
      case (r_idx)
        usb_chan_pkg::IDX_RESULT: begin
          state_d.rbyte = 8'h00;
          state_d.rbyte[usb_chan_pkg::RESULT_MSB:usb_chan_pkg::RESULT_LSB] =
            state_q.result;
        end
        usb_chan_pkg::IDX_CONFIG: begin
          state_d.rbyte = state_q.cfg;
        end
        usb_chan_pkg::IDX_EVENT: begin
          state_d.rbyte = 8'h00;
          state_d.rbyte[usb_chan_pkg::EVT_ACK_BIT] = state_q.ack_flag;
          state_d.rbyte[usb_chan_pkg::EVT_STOP_BIT] = state_q.stop_flag;
        end
        default: begin
          state_d.rbyte = 8'h00;
          state_d.rresp = usb_chan_pkg::AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= '0;
      state_q.wr_state <= usb_chan_pkg::WR_COLLECT;
      state_q.cfg <= usb_chan_pkg::CONFIG_RESET;
      state_q.result <= usb_chan_pkg::RES_CLEAN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign bvalid = (state_q.wr_state == usb_chan_pkg::WR_RESP);
  assign bresp = state_q.bresp;
  assign rvalid = state_q.rvalid;
  assign rdata = {24'h000000, state_q.rbyte};
  assign rresp = state_q.rresp;
  assign chan_cfg = state_q.cfg;
  assign ctl_result = state_q.result;
  assign ack_count_reached_flag = state_q.ack_flag;
  assign stop_done_flag = state_q.stop_flag;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_result_update;
    ctl_done |=> ctl_result == $past(class_code);
  endproperty
  a_result_update: assert property (p_result_update)
    else $error("result not loaded at transfer end");

  property p_result_hold;
    !ctl_done |=> $stable(ctl_result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without transfer end");

  property p_no_reserved;
    ctl_result <= usb_chan_pkg::RES_RETRY;
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved result code produced");

  property p_timeout_retry;
    ctl_done && ctl_status.no_response |=>
      ctl_result == usb_chan_pkg::RES_RETRY;
  endproperty
  a_timeout_retry: assert property (p_timeout_retry)
    else $error("timeout not reported as retry");

  property p_stall;
    ctl_done && ctl_status.stall && !ctl_status.no_response &&
    !ctl_status.pid_check_err && !ctl_status.pid_invalid |=>
      ctl_result == usb_chan_pkg::RES_STALL;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall not reported");

  property p_short_toggle;
    ctl_done && !ctl_status.stall && ctl_status.toggle_mismatch &&
    ctl_rx_len < ctl_max_pkt |=> ctl_result == usb_chan_pkg::RES_RETRY;
  endproperty
  a_short_toggle: assert property (p_short_toggle)
    else $error("short packet toggle mismatch not retry");

  property p_speed_legal;
    chan_cfg.speed < usb_chan_pkg::SPEED_FIRST_BAD;
  endproperty
  a_speed_legal: assert property (p_speed_legal)
    else $error("prohibited speed code held");

  property p_stop_done;
    txn_end && state_q.stop_pending |=> stop_done_flag;
  endproperty
  a_stop_done: assert property (p_stop_done)
    else $error("stop-done flag missing");

  property p_ack_flag;
    ack_reached |=> ack_count_reached_flag;
  endproperty
  a_ack_flag: assert property (p_ack_flag)
    else $error("ack target flag not set");

  property p_toggle_track;
    toggle_upd && !(commit && c_lane0 && !txn_busy &&
                    c_idx == usb_chan_pkg::IDX_CONFIG) |=>
      chan_cfg.toggle == $past(toggle_val);
  endproperty
  a_toggle_track: assert property (p_toggle_track)
    else $error("toggle does not follow engine");

  property p_launch_start;
    launch_rise |=> chan_cfg.launch;
  endproperty
  a_launch_start: assert property (p_launch_start)
    else $error("launch write did not start");

  c_stall: cover property (ctl_done && class_code == usb_chan_pkg::RES_STALL);
  c_stop: cover property (launch_rise ##[1:50] stop_done_flag);
  c_ack: cover property (ack_reached);
endmodule
`default_nettype wire

/* File: shared/usb_chan_pkg.sv */
// constants and carrier types for the host channel result/config block
package usb_chan_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int LEN_W = 10;
  localparam int TOT_W = 32;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_RESULT = 10'h18E;
  localparam logic [9:0] IDX_CONFIG = 10'h190;
  localparam logic [9:0] IDX_EVENT = 10'h198;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // result codes
  localparam logic [2:0] RES_CLEAN = 3'h0;
  localparam logic [2:0] RES_STALL = 3'h1;
  localparam logic [2:0] RES_OVERRUN = 3'h2;
  localparam logic [2:0] RES_UNDERRUN = 3'h3;
  localparam logic [2:0] RES_RETRY = 3'h4;
  // field positions
  localparam int RESULT_LSB = 4;
  localparam int RESULT_MSB = 6;
  localparam int CFG_ACK_LSB = 4;
  localparam int CFG_ACK_MSB = 7;
  localparam int CFG_SPEED_LSB = 2;
  localparam int CFG_SPEED_MSB = 3;
  localparam int CFG_TOGGLE_BIT = 1;
  localparam int CFG_LAUNCH_BIT = 0;
  localparam int EVT_ACK_BIT = 0;
  localparam int EVT_STOP_BIT = 1;
  // peer speed codes; codes at or above SPEED_FIRST_BAD are prohibited
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_FS = 2'h1;
  localparam logic [1:0] SPEED_FIRST_BAD = 2'h2;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [3:0] ACK_CODE_FULL = 4'h0;
  localparam logic [4:0] ACK_FULL_COUNT = 5'h10;

  typedef struct packed {
    logic no_response;
    logic pid_check_err;
    logic pid_invalid;
    logic stall;
    logic crc_err;
    logic stuff_err;
    logic toggle_mismatch;
  } pkt_status_type;

  typedef struct packed {
    logic [3:0] ack_code;
    logic [1:0] speed;
    logic toggle;
    logic launch;
  } chan_cfg_type;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } wr_state_type;
endpackage

/* File: hw/result_classifier.sv */
// classifies how a control-channel transfer ended into a result code
`timescale 1ns/10ps
`default_nettype none
module result_classifier #(
  parameter int LEN_W = usb_chan_pkg::LEN_W,
  parameter int TOT_W = usb_chan_pkg::TOT_W
) (
  input wire usb_chan_pkg::pkt_status_type status, // packet checks
  input wire logic [LEN_W-1:0] rx_len, // bytes in last packet
  input wire logic [LEN_W-1:0] max_pkt, // max packet size
  input wire logic [TOT_W-1:0] rx_total, // bytes received so far
  input wire logic [TOT_W-1:0] budget, // transfer byte budget
  output logic [2:0] code // classified result
);
  logic over;
  logic short_pkt;
  logic under;
  logic both_err;

  always_comb begin
    over = (rx_len > max_pkt) || (rx_total > budget);
    short_pkt = rx_len < max_pkt;
    under = short_pkt && (rx_total < budget);
    both_err = status.crc_err && status.stuff_err;
    // link-level failures come first: no packet to judge
    if (status.no_response || status.pid_check_err || status.pid_invalid) begin
      code = usb_chan_pkg::RES_RETRY;
    end else if (status.stall) begin
      code = usb_chan_pkg::RES_STALL;
    end else if ((over || under) && both_err) begin
      code = usb_chan_pkg::RES_RETRY;
    end else if (short_pkt && status.toggle_mismatch) begin
      code = usb_chan_pkg::RES_RETRY;
    end else if (over) begin
      code = usb_chan_pkg::RES_OVERRUN;
    end else if (under) begin
      code = usb_chan_pkg::RES_UNDERRUN;
    end else if (status.crc_err || status.stuff_err ||
                 status.toggle_mismatch) begin
      code = usb_chan_pkg::RES_RETRY;
    end else begin
      code = usb_chan_pkg::RES_CLEAN;
    end
  end
endmodule
`default_nettype wire

/* File: hw/ack_counter.sv */
// counts ACKs on the general channel up to the programmed target
`timescale 1ns/10ps
`default_nettype none
module ack_counter #(
  parameter int CNT_W = 5
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic restart, // new transaction launched
  input wire logic ack_pulse, // one ACK seen
  input wire logic bot_active, // bulk-only assist running
  input wire logic ack_is_data, // ACK belongs to data transport
  input wire logic [3:0] target_code, // programmed count code
  output logic reached // one-cycle pulse on target met
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic reached;
  } ack_state_type;

  ack_state_type state_q;
  ack_state_type state_d;
  logic [CNT_W-1:0] target;
  logic counted;

  always_comb begin
    state_d = state_q;
    state_d.reached = 1'b0;
    target = (target_code == usb_chan_pkg::ACK_CODE_FULL) ?
             CNT_W'(usb_chan_pkg::ACK_FULL_COUNT) : CNT_W'(target_code);
    // assist traffic for CBW/CSW must not advance the count
    counted = ack_pulse && (!bot_active || ack_is_data);
    if (restart) begin
      state_d.count = '0;
    end else if (counted) begin
      if (state_q.count + CNT_W'(1) == target) begin
        state_d.count = '0;
        state_d.reached = 1'b1;
      end else begin
        state_d.count = state_q.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reached = state_q.reached;
endmodule
`default_nettype wire

/* File: testbench/usb_engine_model.sv */
// far-side transfer engine model driving the block's engine inputs
`timescale 1ns/10ps
`default_nettype none
module usb_engine_model (
  input wire logic clk, // system clock
  output logic ctl_done, // transfer end pulse
  output usb_chan_pkg::pkt_status_type ctl_status, // end checks
  output logic [9:0] ctl_rx_len, // last packet length
  output logic [9:0] ctl_max_pkt, // max packet size
  output logic [31:0] ctl_rx_total, // bytes received
  output logic [31:0] ctl_budget, // byte budget
  output logic txn_busy, // transaction in flight
  output logic txn_end, // transaction ended
  output logic xfer_complete, // budget done
  output logic ack_pulse, // one ACK
  output logic bot_active, // bulk-only assist running
  output logic ack_is_data, // ACK from data transport
  output logic toggle_upd, // live toggle strobe
  output logic toggle_val // live toggle value
);
  initial begin
    {ctl_done, ctl_status, ctl_rx_len, ctl_max_pkt} = '0;
    {ctl_rx_total, ctl_budget, txn_busy, txn_end, xfer_complete} = '0;
    {ack_pulse, bot_active, ack_is_data, toggle_upd, toggle_val} = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // settle margin so sticky flags land before the next register read
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask
  task automatic finish_ctl(input logic [6:0] st, input logic [9:0] len,
      input logic [9:0] mp, input logic [31:0] tot, input logic [31:0] bud);
    @(posedge clk);
    ctl_done <= 1'b1;
    ctl_status <= st;
    {ctl_rx_len, ctl_max_pkt, ctl_rx_total, ctl_budget} <= {len, mp, tot, bud};
    @(posedge clk);
    ctl_done <= 1'b0;
    // qualifiers gone: show garbage, not the last value
    ctl_status <= ~st;
    {ctl_rx_len, ctl_max_pkt} <= ~{len, mp};
    {ctl_rx_total, ctl_budget} <= ~{tot, bud};
  endtask
  task automatic acks(input int n, input logic data);
    repeat (n) begin
      @(posedge clk);
      ack_pulse <= 1'b1;
      ack_is_data <= data;
    end
    @(posedge clk);
    ack_pulse <= 1'b0;
    ack_is_data <= ~data;
    settle();
  endtask
  task automatic set_lvl(input logic busy, input logic bot);
    @(posedge clk);
    txn_busy <= busy;
    bot_active <= bot;
  endtask
  task automatic pulse(input int which, input logic v);
    @(posedge clk);
    if (which == 0) txn_end <= 1'b1;
    if (which == 1) xfer_complete <= 1'b1;
    if (which == 2) {toggle_upd, toggle_val} <= {1'b1, v};
    @(posedge clk);
    {txn_end, xfer_complete, toggle_upd, toggle_val} <= {3'b000, ~v};
    settle();
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the host channel result/config block
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    logic rd;
    logic [1:0] resp;
    logic [31:0] data;
  } note_type;
  localparam logic [11:0] A_RES = {usb_chan_pkg::IDX_RESULT, 2'b00};
  localparam logic [11:0] A_CFG = {usb_chan_pkg::IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_EVT = {usb_chan_pkg::IDX_EVENT, 2'b00};
  localparam logic [1:0] OK = usb_chan_pkg::AXI_OKAY;
  localparam logic [1:0] ERR = usb_chan_pkg::AXI_SLVERR;
  logic clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ctl_done, txn_busy, txn_end;
  logic xfer_complete, ack_pulse, bot_active, ack_is_data, toggle_upd;
  logic toggle_val, ack_flag, stop_flag;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ctl_rx_total, ctl_budget;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] ctl_rx_len, ctl_max_pkt;
  logic [2:0] ctl_result;
  usb_chan_pkg::pkt_status_type ctl_status;
  usb_chan_pkg::chan_cfg_type cfg;
  note_type notes[$];
  note_type got;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'he717;
  int l, t;
  usb_host_channel_result_config i_dut (.clk(clk), .reset_n(reset_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .ctl_done(ctl_done),
    .ctl_status(ctl_status), .ctl_rx_len(ctl_rx_len),
    .ctl_max_pkt(ctl_max_pkt), .ctl_rx_total(ctl_rx_total),
    .ctl_budget(ctl_budget), .txn_busy(txn_busy), .txn_end(txn_end),
    .xfer_complete(xfer_complete), .ack_pulse(ack_pulse),
    .bot_active(bot_active), .ack_is_data(ack_is_data),
    .toggle_upd(toggle_upd), .toggle_val(toggle_val), .chan_cfg(cfg),
    .ctl_result(ctl_result), .ack_count_reached_flag(ack_flag),
    .stop_done_flag(stop_flag));
  usb_engine_model i_eng (.clk(clk), .ctl_done(ctl_done),
    .ctl_status(ctl_status), .ctl_rx_len(ctl_rx_len),
    .ctl_max_pkt(ctl_max_pkt), .ctl_rx_total(ctl_rx_total),
    .ctl_budget(ctl_budget), .txn_busy(txn_busy), .txn_end(txn_end),
    .xfer_complete(xfer_complete), .ack_pulse(ack_pulse),
    .bot_active(bot_active), .ack_is_data(ack_is_data),
    .toggle_upd(toggle_upd), .toggle_val(toggle_val));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic finish_test;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // answers are judged apart from the driver, oldest note first
  always @(posedge clk) begin
    if ((bvalid === 1'b1 && bready) || (rvalid === 1'b1 && rready)) begin
      if (notes.size() == 0) chk(32'h1, 32'h0);
      else begin
        got = notes.pop_front();
        if (got.rd) chk({rresp, rdata}, {got.resp, got.data});
        else chk({30'h0, bresp}, {30'h0, got.resp});
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] r);
    int k;
    logic [31:0] rnd;
    rnd = $random(seed);
    notes.push_back('{1'b0, r, 32'h0});
    @(posedge clk);
    {awvalid, wvalid, bready, awaddr, wstrb} <= {3'b111, a, 4'hF};
    wdata <= {rnd[31:8], d}; // upper lanes carry noise
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
    int k;
    notes.push_back('{1'b1, r, d});
    @(posedge clk);
    {arvalid, rready, araddr} <= {2'b11, a};
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    if (k >= 50) failures++;
    rready <= 1'b0;
  endtask
  task automatic res(input logic [6:0] st, input logic [9:0] len,
      input logic [31:0] tot, input logic [31:0] bud, input logic [2:0] c);
    i_eng.finish_ctl(st, len, 10'h040, tot, bud);
    rd(A_RES, {25'h0, c, 4'h0}, OK);
    chk({29'h0, ctl_result}, {29'h0, c});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    finish_test();
  end
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(A_RES, 32'h0, OK);
    rd(A_CFG, 32'h0, OK);
    rd(12'h004, 32'h0, ERR);
    wr(12'h004, 8'h01, ERR);
    res(7'h00, 10'h040, 32'd100, 32'd100, 3'h0);
    res(7'h08, 10'h040, 32'd100, 32'd100, 3'h1);
    res(7'h00, 10'h041, 32'd100, 32'd200, 3'h2);
    res(7'h00, 10'h040, 32'd300, 32'd200, 3'h2);
    res(7'h00, 10'h00A, 32'd50, 32'd200, 3'h3);
    res(7'h06, 10'h041, 32'd100, 32'd200, 3'h4);
    res(7'h06, 10'h00A, 32'd50, 32'd200, 3'h4);
    res(7'h01, 10'h00A, 32'd300, 32'd200, 3'h4);
    res(7'h40, 10'h040, 32'd100, 32'd100, 3'h4);
    res(7'h20, 10'h040, 32'd100, 32'd100, 3'h4);
    res(7'h10, 10'h040, 32'd100, 32'd100, 3'h4);
    res(7'h04, 10'h040, 32'd100, 32'd100, 3'h4);
    res(7'h02, 10'h040, 32'd100, 32'd100, 3'h4);
    res(7'h04, 10'h041, 32'd100, 32'd200, 3'h2);
    repeat (4) begin
      l = 1 + ($unsigned($random(seed)) % 63);
      t = $unsigned($random(seed)) % 200;
      res(7'h00, l[9:0], t, 32'd200, 3'h3);
    end
    wr(A_RES, 8'hFF, OK);
    rd(A_RES, 32'h30, OK);
    wr(A_CFG, 8'h04, OK);
    rd(A_CFG, 32'h04, OK);
    wr(A_CFG, 8'h08, OK);
    rd(A_CFG, 32'h04, OK);
    wr(A_CFG, 8'h0C, OK);
    rd(A_CFG, 32'h04, OK);
    wr(A_CFG, 8'h31, OK);
    rd(A_CFG, 32'h31, OK);
    i_eng.acks(2, 1'b1);
    rd(A_EVT, 32'h0, OK);
    i_eng.acks(1, 1'b1);
    rd(A_EVT, 32'h1, OK);
    wr(A_EVT, 8'h03, OK);
    rd(A_EVT, 32'h0, OK);
    wr(A_CFG, 8'h00, OK);
    wr(A_CFG, 8'h01, OK);
    i_eng.acks(15, 1'b1);
    rd(A_EVT, 32'h0, OK);
    i_eng.acks(1, 1'b1);
    rd(A_EVT, 32'h1, OK);
    wr(A_EVT, 8'h01, OK);
    wr(A_CFG, 8'h00, OK);
    i_eng.set_lvl(1'b0, 1'b1); // assist running, channel idle: only data-transport ACKs count
    wr(A_CFG, 8'h21, OK);
    i_eng.acks(3, 1'b0);
    i_eng.acks(1, 1'b1);
    rd(A_EVT, 32'h0, OK);
    i_eng.acks(1, 1'b1);
    rd(A_EVT, 32'h1, OK);
    wr(A_EVT, 8'h01, OK);
    i_eng.set_lvl(1'b1, 1'b0);
    wr(A_CFG, 8'h00, OK);
    rd(A_CFG, 32'h0, OK);
    wr(A_CFG, 8'h01, OK);
    wr(A_CFG, 8'h00, OK);
    rd(A_EVT, 32'h0, OK);
    i_eng.pulse(0, 1'b0);
    rd(A_EVT, 32'h2, OK);
    wr(A_CFG, 8'h02, OK);
    rd(A_CFG, 32'h0, OK);
    i_eng.set_lvl(1'b0, 1'b0);
    i_eng.pulse(2, 1'b1);
    rd(A_CFG, 32'h02, OK);
    // keep toggle at 1: an idle channel takes the written toggle value
    wr(A_CFG, 8'h03, OK);
    i_eng.pulse(1, 1'b0);
    rd(A_CFG, 32'h02, OK);
    repeat (4) @(posedge clk);
    chk({22'h0, stop_flag, ack_flag, cfg}, 32'h202);
    finish_test();
  end
endmodule
`default_nettype wire
